// File: include/emsp_pkg.sv
`default_nettype none
package emsp_pkg;
   // Access kinds requested by the core
   typedef enum logic [2:0] {
      EMSP_OP_ASYNC_RD   = 3'h0,
      EMSP_OP_ASYNC_WR   = 3'h1,
      EMSP_OP_SYNC_RD    = 3'h2,
      EMSP_OP_SYNC_WR    = 3'h3,
      EMSP_OP_SDRAM      = 3'h4
   } emsp_op_e;

   // SDRAM commands; encoding is {ras_n, cas_n, we_n}
   typedef enum logic [2:0] {
      EMSP_CMD_NOP       = 3'h7,
      EMSP_CMD_ACTIVATE  = 3'h3,
      EMSP_CMD_READ      = 3'h5,
      EMSP_CMD_WRITE     = 3'h4,
      EMSP_CMD_PRE_ALL   = 3'h2,
      EMSP_CMD_PRE_BANK  = 3'h6,
      EMSP_CMD_REFRESH   = 3'h1,
      EMSP_CMD_MODE_SET  = 3'h0
   } emsp_sdcmd_e;

   localparam logic [2:0] EMSP_CMD_SELF_ENTER = 3'h1;
   localparam logic [1:0] EMSP_CAS_LATENCY    = 2'h3;
   localparam logic [1:0] EMSP_SPACE_DEF      = 2'h0;

   // Address field positions for SDRAM column commands
   localparam int EMSP_BANK_HI = 21;
   localparam int EMSP_BANK_LO = 13;
   localparam int EMSP_A12     = 12;
   localparam int EMSP_COL_HI  = 11;
   localparam int EMSP_COL_LO  = 2;

   // Per-space synchronous configuration
   typedef struct packed {
      logic [1:0] sync_read_latency;
      logic [1:0] sync_write_latency;
      logic       chip_select_extend;
      logic       strobe_fifo_read_select;
      logic       sync_clock_select;
   } emsp_space_cfg_s;

   // Request from the core, reference domain
   typedef struct packed {
      emsp_op_e    op;
      emsp_sdcmd_e sdcmd;
      logic        self_refresh;
      logic [1:0]  space;
      logic [21:2] addr;
      logic        a12;
      logic [3:0]  be_n;
      logic [31:0] wdata;
   } emsp_req_s;

   // Memory pins driven on the link side
   typedef struct packed {
      logic [3:0]  space_chip_select_n;
      logic [3:0]  byte_enable_n;
      logic [21:2] ext_address;
      logic [31:0] data_out;
      logic        data_oe;
      logic        strobe_a_n;
      logic        strobe_b_n;
      logic        strobe_c_n;
      logic        sdram_clock_enable;
   } emsp_pins_s;
endpackage : emsp_pkg
`default_nettype wire

// File: logic/emsp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module emsp_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } emsp_sync_s;

   emsp_sync_s st;
   emsp_sync_s next_st;

   always_comb
   begin
      next_st    = st;
      next_st.s1 = i_d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         st <= '0;
      else
         st <= next_st;
   end

   assign o_q = st.s2;
endmodule : emsp_sync2
`default_nettype wire

// File: logic/emsp_port.sv
// Overview of operation
// - Async accesses use the shared strobes as output enable, read strobe, write strobe.
// - Per-space synchronous read latency of zero to three clock cycles.
// - Per-space synchronous write latency of zero to three clock cycles.
// - Chip-select extend off: chip select drops after the final command.
// - Chip-select extend on: chip select follows the synchronous output enable.
// - FIFO-read select off: strobe is address strobe, deselect cycles inserted.
// - FIFO-read select on: strobe is FIFO read enable, no deselect cycles.
// - Per-space choice of first or second output clock for synchronous transfers.
// - Sync accesses use strobes as address strobe, output enable, write enable.
// - SDRAM accesses use strobes as column strobe, row strobe, write enable.
// - SDRAM reads capture data three cycles after the read command.
// - Sequencer issues activate, precharges, refresh, mode set, self-refresh.
// - All SDRAM outputs change on rising edges of the first output clock only.
`timescale 1ns/1ps
`default_nettype none
module emsp_port #(
   parameter int NSPACE = 4
) (
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_rst,
   input  wire logic                          i_ext_out_clock_a,
   input  wire logic                          i_ext_out_clock_b,
   input  wire emsp_pkg::emsp_space_cfg_s [NSPACE-1:0] i_space_cfg,
   input  wire logic                          i_req_valid,
   input  wire emsp_pkg::emsp_req_s           i_req,
   output logic                               o_req_ready,
   output logic                               o_done,
   output logic [31:0]                        o_rdata,
   input  wire logic [31:0]                   i_data_in,
   output emsp_pkg::emsp_pins_s               o_pins,
   output logic                               o_busy
);
   // ----------------------------------------------------------------
   // Reference domain: request holding and handshake
   // ----------------------------------------------------------------
   typedef struct packed {
      emsp_pkg::emsp_req_s req;
      logic                req_tgl;
      logic                busy;
      logic                ack_seen;
      logic [31:0]         rdata;
      logic                done;
   } emsp_ref_s;

   emsp_ref_s r;
   emsp_ref_s next_r;
   logic      ack_sync;
   logic [31:0] lk_rdata;
   logic      ack_a;
   logic      ack_b;

   // Toggle handshake; the request word is stable while busy so it is
   // safe to read in the link domain once the toggle has synchronised.
   always_comb
   begin
      next_r      = r;
      next_r.done = 1'b0;
      if (!r.busy && i_req_valid)
      begin
         next_r.req     = i_req;
         next_r.req_tgl = ~r.req_tgl;
         next_r.busy    = 1'b1;
      end
      else if (r.busy && (ack_sync != r.ack_seen))
      begin
         next_r.ack_seen = ack_sync;
         next_r.busy     = 1'b0;
         next_r.done     = 1'b1;
         next_r.rdata    = lk_rdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         r <= '0;
      else
         r <= next_r;
   end

   assign o_req_ready = !r.busy;
   assign o_done      = r.done;
   assign o_rdata     = r.rdata;
   assign o_busy      = r.busy;

   // ----------------------------------------------------------------
   // Link domain state, one copy per output clock
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EMSP_ST_IDLE    = 3'h0,
      EMSP_ST_CMD     = 3'h1,
      EMSP_ST_WAIT    = 3'h3,
      EMSP_ST_DESEL   = 3'h2,
      EMSP_ST_ACK     = 3'h6
   } emsp_st_e;

   typedef struct packed {
      emsp_st_e             st;
      logic                 tgl_seen;
      logic                 ack_tgl;
      logic [1:0]           cnt;
      emsp_pkg::emsp_pins_s pins;
      logic [31:0]          rdata;
      logic                 self_ref;
   } emsp_lk_s;

   emsp_lk_s lk_a;
   emsp_lk_s lk_b;
   logic     tgl_a;
   logic     tgl_b;

   emsp_sync2 #(.W(1)) u_req_a (.i_clk(i_ext_out_clock_a), .i_rst(i_rst), .i_d(r.req_tgl), .o_q(tgl_a));
   emsp_sync2 #(.W(1)) u_req_b (.i_clk(i_ext_out_clock_b), .i_rst(i_rst), .i_d(r.req_tgl), .o_q(tgl_b));
   emsp_sync2 #(.W(1)) u_ack_a (.i_clk(i_ref_clk), .i_rst(i_rst), .i_d(lk_a.ack_tgl), .o_q(ack_a));
   emsp_sync2 #(.W(1)) u_ack_b (.i_clk(i_ref_clk), .i_rst(i_rst), .i_d(lk_b.ack_tgl), .o_q(ack_b));

   // Each engine owns its own ack toggle, so their xor marks completion
   assign ack_sync = ack_a ^ ack_b;

   function automatic emsp_pkg::emsp_pins_s emsp_idle_pins(input logic cke);
      emsp_pkg::emsp_pins_s p;
      p                     = '0;
      p.space_chip_select_n = '1;
      p.byte_enable_n       = '1;
      p.strobe_a_n          = 1'b1;
      p.strobe_b_n          = 1'b1;
      p.strobe_c_n          = 1'b1;
      p.sdram_clock_enable  = cke;
      return p;
   endfunction : emsp_idle_pins

   // One engine step; is_a says whether this engine runs on clock a
   function automatic emsp_lk_s emsp_step(input emsp_lk_s s, input logic tgl, input logic is_a,
                                          input emsp_pkg::emsp_req_s q,
                                          input emsp_pkg::emsp_space_cfg_s c,
                                          input logic [31:0] din);
      emsp_lk_s n;
      logic     mine;
      logic [3:0] cs;
      n    = s;
      // SDRAM and async always on clock a; sync ops on the selected clock
      mine = (q.op inside {emsp_pkg::EMSP_OP_SYNC_RD, emsp_pkg::EMSP_OP_SYNC_WR}) ?
             (c.sync_clock_select != is_a) : is_a;
      cs   = ~(4'h1 << q.space);
      case (s.st)
         EMSP_ST_IDLE:
         begin
            n.pins = emsp_idle_pins(s.self_ref);
            if ((tgl != s.tgl_seen) && mine)
            begin
               n.tgl_seen = tgl;
               n.st       = EMSP_ST_CMD;
            end
            else if (tgl != s.tgl_seen)
               n.tgl_seen = tgl;
         end
         EMSP_ST_CMD:
         begin
            n.pins.space_chip_select_n = cs;
            n.pins.byte_enable_n       = q.be_n;
            n.pins.ext_address         = q.addr;
            n.pins.data_out            = q.wdata;
            case (q.op)
               emsp_pkg::EMSP_OP_ASYNC_RD:
               begin
                  n.pins.strobe_a_n = 1'b0;
                  n.pins.strobe_b_n = 1'b0;
                  n.cnt             = '0;
                  n.st              = EMSP_ST_WAIT;
               end
               emsp_pkg::EMSP_OP_ASYNC_WR:
               begin
                  n.pins.data_oe    = 1'b1;
                  n.pins.strobe_c_n = 1'b0;
                  n.cnt             = '0;
                  n.st              = EMSP_ST_WAIT;
               end
               emsp_pkg::EMSP_OP_SYNC_RD:
               begin
                  n.pins.strobe_b_n = 1'b0;
                  n.pins.strobe_a_n = 1'b0;
                  n.cnt             = c.sync_read_latency;
                  n.st              = EMSP_ST_WAIT;
               end
               emsp_pkg::EMSP_OP_SYNC_WR:
               begin
                  n.pins.strobe_a_n = 1'b0;
                  n.pins.strobe_c_n = 1'b0;
                  n.pins.data_oe    = (c.sync_write_latency == 2'h0);
                  n.cnt             = c.sync_write_latency;
                  n.st              = EMSP_ST_WAIT;
               end
               default:
               begin
                  // SDRAM: {ras,cas,we} on strobes b,a,c
                  n.pins.strobe_b_n = q.sdcmd[2];
                  n.pins.strobe_a_n = q.sdcmd[1];
                  n.pins.strobe_c_n = q.sdcmd[0];
                  if (q.sdcmd inside {emsp_pkg::EMSP_CMD_READ, emsp_pkg::EMSP_CMD_WRITE})
                  begin
                     n.pins.ext_address = '0;
                     n.pins.ext_address[emsp_pkg::EMSP_BANK_HI:emsp_pkg::EMSP_BANK_LO] =
                        q.addr[emsp_pkg::EMSP_BANK_HI:emsp_pkg::EMSP_BANK_LO];
                     n.pins.ext_address[emsp_pkg::EMSP_COL_HI:emsp_pkg::EMSP_COL_LO] =
                        q.addr[emsp_pkg::EMSP_COL_HI:emsp_pkg::EMSP_COL_LO];
                     n.pins.ext_address[emsp_pkg::EMSP_A12] = q.a12;
                  end
                  n.pins.data_oe = (q.sdcmd == emsp_pkg::EMSP_CMD_WRITE);
                  if (q.sdcmd == emsp_pkg::EMSP_CMD_REFRESH && q.self_refresh)
                  begin
                     n.pins.sdram_clock_enable = 1'b0;
                     n.self_ref                = 1'b1;
                  end
                  else
                  begin
                     n.pins.sdram_clock_enable = 1'b1;
                     n.self_ref                = 1'b1;
                  end
                  n.cnt = (q.sdcmd == emsp_pkg::EMSP_CMD_READ) ? emsp_pkg::EMSP_CAS_LATENCY : 2'h0;
                  n.st  = EMSP_ST_WAIT;
               end
            endcase
         end
         EMSP_ST_WAIT:
         begin
            // Only one command per access; strobe a drops after it except on FIFO-read sync reads
            n.pins.strobe_a_n = (q.op == emsp_pkg::EMSP_OP_SYNC_RD && c.strobe_fifo_read_select) ?
                                s.pins.strobe_a_n : 1'b1;
            if (q.op == emsp_pkg::EMSP_OP_SDRAM)
            begin
               // Select only frames the one command cycle
               n.pins.space_chip_select_n = '1;
               n.pins.strobe_b_n = 1'b1;
               n.pins.strobe_c_n = 1'b1;
            end
            if (q.op == emsp_pkg::EMSP_OP_SYNC_WR)
            begin
               n.pins.strobe_c_n = 1'b1;
               n.pins.data_oe    = (s.cnt == 2'h1) || (s.cnt == 2'h0 && s.pins.data_oe);
            end
            // Synchronous SRAM: chip select drops after the last command, or follows output enable with extend on
            if (q.op inside {emsp_pkg::EMSP_OP_SYNC_RD, emsp_pkg::EMSP_OP_SYNC_WR})
               n.pins.space_chip_select_n = (c.chip_select_extend && !s.pins.strobe_b_n) ? cs : '1;
            if (s.cnt != 2'h0)
               n.cnt = s.cnt - 2'h1;
            else
            begin
               n.rdata = din;
               n.st    = c.strobe_fifo_read_select ? EMSP_ST_ACK : EMSP_ST_DESEL;
            end
         end
         EMSP_ST_DESEL:
         begin
            n.pins = emsp_idle_pins(s.self_ref);
            n.st   = EMSP_ST_ACK;
         end
         EMSP_ST_ACK:
         begin
            n.pins    = emsp_idle_pins(s.self_ref);
            n.ack_tgl = ~s.ack_tgl;
            n.st      = EMSP_ST_IDLE;
         end
         default:
            n.st = EMSP_ST_IDLE;
      endcase
      if (s.st == EMSP_ST_CMD && q.op == emsp_pkg::EMSP_OP_SDRAM)
         n.self_ref = !(q.sdcmd == emsp_pkg::EMSP_CMD_REFRESH && q.self_refresh) ? 1'b1 : 1'b0;
      return n;
   endfunction : emsp_step

   emsp_lk_s next_lk_a;
   emsp_lk_s next_lk_b;
   emsp_pkg::emsp_space_cfg_s cfg;

   assign cfg = i_space_cfg[r.req.space];

   // Read data is taken from the engine that ran the access; it is stable once the ack toggle crossed
   assign lk_rdata = ((r.req.op inside {emsp_pkg::EMSP_OP_SYNC_RD, emsp_pkg::EMSP_OP_SYNC_WR})
                      && cfg.sync_clock_select) ? lk_b.rdata : lk_a.rdata;

   always_comb
   begin
      next_lk_a = emsp_step(lk_a, tgl_a, 1'b1, r.req, cfg, i_data_in);
      next_lk_b = emsp_step(lk_b, tgl_b, 1'b0, r.req, cfg, i_data_in);
   end

   // Clock enable starts high; self-refresh exit is any later SDRAM command other than another self-refresh refresh
   always_ff @(posedge i_ext_out_clock_a or posedge i_rst)
   begin
      if (i_rst)
      begin
         lk_a          <= '0;
         lk_a.self_ref <= 1'b1;
         lk_a.pins     <= emsp_idle_pins(1'b1);
      end
      else
         lk_a <= next_lk_a;
   end

   always_ff @(posedge i_ext_out_clock_b or posedge i_rst)
   begin
      if (i_rst)
      begin
         lk_b      <= '0;
         lk_b.pins <= emsp_idle_pins(1'b0);
      end
      else
         lk_b <= next_lk_b;
   end

   // Pins come from the engine that owns the access; clock a holds CKE
   always_comb
   begin
      o_pins                    = (lk_b.st != EMSP_ST_IDLE) ? lk_b.pins : lk_a.pins;
      o_pins.sdram_clock_enable = lk_a.pins.sdram_clock_enable;
   end
endmodule : emsp_port
`default_nettype wire

// File: testbench/emsp_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module emsp_port_checker #(
   parameter int NSPACE = 4
) (
   input wire logic                                   i_ref_clk,
   input wire logic                                   i_rst,
   input wire logic                                   i_ext_out_clock_a,
   input wire emsp_pkg::emsp_space_cfg_s [NSPACE-1:0] i_space_cfg,
   input wire logic                                   i_req_valid,
   input wire emsp_pkg::emsp_req_s                    i_req,
   input wire logic                                   o_req_ready,
   input wire logic                                   o_done,
   input wire emsp_pkg::emsp_pins_s                   o_pins,
   input wire logic                                   o_busy
);
   // ---------------------------------------------
   // Helpers: request is held steady by the bench
   // ---------------------------------------------
   emsp_pkg::emsp_space_cfg_s cf;
   logic                      cs;
   logic                      syn;
   logic [2:0]                cmd;
   assign cf  = i_space_cfg[i_req.space];
   assign cs  = !o_pins.space_chip_select_n[i_req.space];
   assign syn = i_req.op inside {emsp_pkg::EMSP_OP_SYNC_RD, emsp_pkg::EMSP_OP_SYNC_WR};
   assign cmd = {o_pins.strobe_b_n, o_pins.strobe_a_n, o_pins.strobe_c_n};
   sequence self_cmd;
      i_req.op == emsp_pkg::EMSP_OP_SDRAM && i_req.self_refresh && cs
         && i_req.sdcmd == emsp_pkg::EMSP_CMD_REFRESH;
   endsequence
   // ---------------------------------------------
   // Core side handshake
   // ---------------------------------------------
   take_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_req_valid && o_req_ready |=> o_busy) else $error("taken request did not set busy");
   busy_refuse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_busy |-> !o_req_ready) else $error("ready while busy");
   done_once_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_done |=> !o_done) else $error("done longer than one cycle");
   done_bound_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_busy) |-> ##[2:80] o_done) else $error("access never finished");
   // ---------------------------------------------
   // Pin roles, checked on the first output clock
   // ---------------------------------------------
   async_read_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      i_req.op == emsp_pkg::EMSP_OP_ASYNC_RD && !o_pins.strobe_a_n |-> o_pins.strobe_c_n)
      else $error("write strobe during async read");
   sync_rd_we_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      i_req.op == emsp_pkg::EMSP_OP_SYNC_RD |-> o_pins.strobe_c_n) else $error("write enable on sync read");
   cs_extend_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      syn && cf.chip_select_extend && !o_pins.strobe_b_n |-> cs) else $error("select dropped under oe");
   cs_drop_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      syn && !cf.chip_select_extend && !cf.strobe_fifo_read_select && cs |-> !o_pins.strobe_a_n)
      else $error("select held past command");
   sd_cmd_map_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      i_req.op == emsp_pkg::EMSP_OP_SDRAM && cs |-> cmd == i_req.sdcmd) else $error("wrong sdram command");
   sd_addr_map_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      i_req.op == emsp_pkg::EMSP_OP_SDRAM && cs && cmd inside {3'h5, 3'h4}
      |-> o_pins.ext_address[21:13] == i_req.addr[21:13] && o_pins.ext_address[11:2] == i_req.addr[11:2])
      else $error("bank or column misplaced");
   self_cke_a: assert property (@(posedge i_ext_out_clock_a) disable iff (i_rst)
      self_cmd |-> ##[0:3] !o_pins.sdram_clock_enable) else $error("clock enable kept in self refresh");
endmodule : emsp_port_checker
`default_nettype wire

// File: testbench/emsp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emsp_mem_model (
   input wire logic                 i_clk_a,
   input wire logic                 i_clk_b,
   input wire logic                 i_sel_b,
   input wire emsp_pkg::emsp_pins_s i_pins,
   output logic [31:0]              o_data
);
   // ---------------------------------------------
   // Read data window after a read command
   // ---------------------------------------------
   logic        clk;
   logic        hit;
   logic [19:0] addr = '0;
   logic [2:0]  cnt  = '0;
   logic [31:0] last = '0;
   assign clk = i_sel_b ? i_clk_b : i_clk_a;
   assign hit = !(&i_pins.space_chip_select_n) && !i_pins.strobe_a_n && i_pins.strobe_c_n;
   // Window covers latency up to three plus capture slack; outside it the bus toggles
   always @(posedge clk)
   begin
      if (hit)
      begin
         addr <= i_pins.ext_address;
         cnt  <= 3'h5;
      end
      else if (cnt != 3'h0)
         cnt <= cnt - 3'h1;
      last <= o_data;
   end
   assign o_data = hit ? ({10'h0, i_pins.ext_address, 2'h0} ^ 32'h5a5a0000)
                 : (cnt != 3'h0) ? ({10'h0, addr, 2'h0} ^ 32'h5a5a0000) : ~last;
endmodule : emsp_mem_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int NSPACE = 4;
   typedef struct packed {
      emsp_pkg::emsp_op_e    op;
      emsp_pkg::emsp_sdcmd_e cmd;
      logic [1:0]            lat;
      logic                  ext;
      logic                  fifo;
      logic                  clk;
   } emsp_row_s;
   logic                                i_ref_clk   = 1'b0;
   logic                                i_rst       = 1'b1;
   logic                                clk_a       = 1'b0;
   logic                                clk_b       = 1'b0;
   logic                                sel_b       = 1'b0;
   logic                                i_req_valid = 1'b0;
   emsp_pkg::emsp_space_cfg_s [NSPACE-1:0] i_space_cfg = '0;
   emsp_pkg::emsp_req_s                 i_req       = '0;
   logic                                o_req_ready;
   logic                                o_done;
   logic                                o_busy;
   logic [31:0]                         o_rdata;
   logic [31:0]                         mem_data;
   emsp_pkg::emsp_pins_s                o_pins;
   int                                  n_errors    = 0;
   int                                  checks      = 0;
   emsp_row_s                           rows [18];
   // ---------------------------------------------
   // Clocks and instances
   // ---------------------------------------------
   always #25 i_ref_clk = ~i_ref_clk;
   initial begin #7; forever #40 clk_a = ~clk_a; end
   initial begin #29; forever #40 clk_b = ~clk_b; end
   emsp_port #(.NSPACE(NSPACE)) emsp_port_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ext_out_clock_a(clk_a),
      .i_ext_out_clock_b(clk_b), .i_space_cfg(i_space_cfg), .i_req_valid(i_req_valid), .i_req(i_req),
      .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata), .i_data_in(mem_data),
      .o_pins(o_pins), .o_busy(o_busy));
   emsp_mem_model emsp_mem_model_i (.i_clk_a(clk_a), .i_clk_b(clk_b), .i_sel_b(sel_b), .i_pins(o_pins),
      .o_data(mem_data));
   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   function automatic logic [31:0] pat(input logic [19:0] a);
      return {10'h0, a, 2'h0} ^ 32'h5a5a0000;
   endfunction : pat
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic idle_chk();
      chk("idle pins", {24'h0, o_pins.space_chip_select_n, o_pins.strobe_a_n, o_pins.strobe_b_n,
         o_pins.strobe_c_n, o_pins.sdram_clock_enable}, 32'hff);
   endtask : idle_chk
   task automatic start(input emsp_row_s r, input logic [19:0] a, input logic [1:0] sp, input logic self);
      int n;
      n = 0;
      i_space_cfg[sp] <= {r.lat, r.lat, r.ext, r.fifo, r.clk};
      sel_b <= r.clk && (r.op inside {emsp_pkg::EMSP_OP_SYNC_RD, emsp_pkg::EMSP_OP_SYNC_WR});
      i_req <= '{op: r.op, sdcmd: r.cmd, self_refresh: self, space: sp, addr: a, a12: a[10], be_n: 4'h0,
                 wdata: pat(a)};
      @(posedge i_ref_clk);
      i_req_valid <= 1'b1;
      do begin @(negedge i_ref_clk); n++; end while (o_req_ready !== 1'b1 && n < 100);
      @(posedge i_ref_clk);
      i_req_valid <= 1'b0;
      @(posedge i_ref_clk);
      chk("ready while busy", {31'h0, o_req_ready}, 32'h0);
   endtask : start
   task automatic run(input emsp_row_s r, input logic [19:0] a, input logic [1:0] sp, input logic self);
      int n;
      n = 0;
      start(r, a, sp, self);
      while (o_done !== 1'b1 && n < 200) begin @(negedge i_ref_clk); n++; end
      chk("done", {31'h0, o_done}, 32'h1);
      if (r.op inside {emsp_pkg::EMSP_OP_ASYNC_RD, emsp_pkg::EMSP_OP_SYNC_RD}
          || (r.op == emsp_pkg::EMSP_OP_SDRAM && r.cmd == emsp_pkg::EMSP_CMD_READ))
         chk("read data", o_rdata, pat(a));
      @(posedge i_ref_clk);
   endtask : run
   task automatic give_verdict();
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // ---------------------------------------------
   // Sequence: table, then awkward cases
   // ---------------------------------------------
   initial
   begin
      #400000;
      n_errors++;
      give_verdict();
   end
   initial
   begin
      for (int i = 0; i < 4; i++)
      begin
         rows[i]   = '{emsp_pkg::EMSP_OP_SYNC_RD, emsp_pkg::EMSP_CMD_NOP, 2'(i), i[0], i[1], i[0]};
         rows[i+4] = '{emsp_pkg::EMSP_OP_SYNC_WR, emsp_pkg::EMSP_CMD_NOP, 2'(3-i), i[1], i[0], !i[0]};
      end
      rows[8] = '{emsp_pkg::EMSP_OP_ASYNC_RD, emsp_pkg::EMSP_CMD_NOP, 2'h0, 1'b0, 1'b0, 1'b0};
      rows[9] = '{emsp_pkg::EMSP_OP_ASYNC_WR, emsp_pkg::EMSP_CMD_NOP, 2'h0, 1'b0, 1'b0, 1'b0};
      // Clock select is set to b on SDRAM rows too: the port must still run them on clock a
      for (int i = 0; i < 8; i++)
         rows[10+i] = '{emsp_pkg::EMSP_OP_SDRAM, emsp_pkg::emsp_sdcmd_e'(i[2:0]), 2'h0, 1'b0, 1'b0, 1'b1};
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      idle_chk();
      for (int i = 0; i < 18; i++)
         run(rows[i], 20'(32'h3a5c7 * (i + 1)), i[1:0], 1'b0);
      run(rows[11], 20'h00401, 2'h1, 1'b1);
      chk("cke in self refresh", {31'h0, o_pins.sdram_clock_enable}, 32'h0);
      run(rows[17], 20'h00802, 2'h1, 1'b0);
      chk("cke after exit", {31'h0, o_pins.sdram_clock_enable}, 32'h1);
      start(rows[3], 20'h12345, 2'h2, 1'b0);
      i_rst <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      idle_chk();
      chk("busy in reset", {31'h0, o_busy}, 32'h0);
      i_rst <= 1'b0;
      run(rows[3], 20'h54321, 2'h2, 1'b0);
      give_verdict();
   end
endmodule : testbench
bind emsp_port emsp_port_checker #(.NSPACE(NSPACE)) emsp_port_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_ext_out_clock_a(i_ext_out_clock_a), .i_space_cfg(i_space_cfg), .i_req_valid(i_req_valid),
   .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_pins(o_pins), .o_busy(o_busy));
`default_nettype wire
